/* File: hw/adc_fmt_consts.vh */
// Constants for the output formatting and power control block
`ifndef ADC_FMT_CONSTS_VH
`define ADC_FMT_CONSTS_VH

`define WORD_W          10
`define PAIR_N          5
`define FIFO_DEPTH      32
`define FIFO_AW         5

// Output formats
`define FMT_OFFSET_BIN  2'h0
`define FMT_TWOS_COMP   2'h1
`define FMT_GRAY        2'h2

// Power modes
`define PWR_NORMAL      2'h0
`define PWR_NAP         2'h1
`define PWR_SLEEP       2'h2

// Tri-level power pin levels
`define PIN_GROUND      2'h0
`define PIN_FLOAT       2'h1
`define PIN_SUPPLY      2'h2

// Serial power register wake code, top three bits of four
`define WAKE_CODE       3'h1
`define PWR_REG_ADDR    8'h25

// Drive current settings
`define DRIVE_3MA       1'b0
`define DRIVE_2MA       1'b1

// Clock in MHz, times in ns
`define CLK_MHZ         20
`define NAP_WAKE_NS     1000
`define SLEEP_WAKE_NS   1000000
`define RELOCK_NS       52000
`define NAP_WAKE_CYC    ((`NAP_WAKE_NS * `CLK_MHZ) / 1000)
`define SLEEP_WAKE_CYC  ((`SLEEP_WAKE_NS * `CLK_MHZ) / 1000)
`define RELOCK_CYC      ((`RELOCK_NS * `CLK_MHZ) / 1000)

// Pipeline latency in half cycles (7.5 cycles)
`define LAT_HALF        15
`define LAT_FULL        7

`endif

/* File: hw/word_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_r;
  reg [AW:0]      rd_r;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty     = (wr_r == rd_r);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_r[AW-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  always @(posedge clock)
  begin
    if (push)
      mem[wr_r[AW-1:0]] <= in_data;
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_r <= wr_r + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_r <= rd_r + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

/* File: hw/adc_output_format_power_ctrl.v */
// Output formatting, DDR presentation, over-range and power states
`timescale 1ns/1ps
`include "adc_fmt_consts.vh"
module adc_output_format_power_ctrl #(
  parameter SLEEP_WAKE = `SLEEP_WAKE_CYC,
  parameter RELOCK     = `RELOCK_CYC
) (
  input  wire                 clock,
  input  wire                 arst_n,
  input  wire                 calibration_reset_n,
  input  wire                 cal_done,
  input  wire [`WORD_W-1:0]   sample_data,
  input  wire                 sample_valid,
  input  wire                 sample_over,
  input  wire [1:0]           tri_level_power_pin,
  input  wire                 serial_select_n,
  input  wire                 clock_stopped,
  input  wire                 clock_freq_change,
  input  wire [1:0]           fmt_sel,
  input  wire                 drive_low_sel,
  input  wire                 div2_sel,
  input  wire                 pwr_wr,
  input  wire [3:0]           pwr_wr_data,
  input  wire                 pwr_wr_idx_ok,
  output reg  [`PAIR_N-1:0]   data_pair_o,
  output reg  [`PAIR_N-1:0]   data_pair_oe,
  output reg                  forwarded_output_strobe,
  output reg                  strobe_oe,
  output reg                  over_range_o,
  output reg                  over_range_oe,
  output reg                  drive_2ma,
  output reg  [1:0]           power_mode,
  output reg                  ready,
  output reg                  locked
);
  localparam ST_RUN   = 2'h0;
  localparam ST_LOW   = 2'h1;
  localparam ST_WAKE  = 2'h2;
  localparam ST_LOCK  = 2'h3;

  localparam [19:0] NAP_CNT   = `NAP_WAKE_CYC;
  localparam [19:0] SLEEP_CNT = SLEEP_WAKE;
  localparam [19:0] LOCK_CNT  = RELOCK;

  reg [1:0]          st_r;
  reg [19:0]         cnt_r;
  reg                ser_ovr_r;
  reg [1:0]          ser_mode_r;
  reg                nap_stop_r;
  reg                div_ph_r;
  reg                phase_r;
  reg [`WORD_W-1:0]  word_r;
  reg                or_r;
  reg [`LAT_FULL-1:0] lat_v_r;
  reg [`WORD_W-1:0]  lat_d_r [0:`LAT_FULL-1];
  reg [`LAT_FULL-1:0] lat_o_r;
  reg [1:0]          tgt_mode;
  reg [`WORD_W-1:0]  enc;
  reg [`WORD_W-1:0]  clamped;
  reg [`PAIR_N-1:0]  half_bits;
  wire               out_en;
  wire               tick;
  // Top bit carries the over-range flag beside its word
  wire [`WORD_W:0]   fifo_data;
  wire [`WORD_W-1:0] head;
  wire               fifo_valid;
  wire               fifo_pop;
  integer            i;
  integer            j;

  assign tick   = div2_sel ? div_ph_r : 1'b1;
  assign out_en = (st_r == ST_RUN) & calibration_reset_n;
  // One word leaves per full strobe period, taken at the odd half
  assign fifo_pop = out_en & tick & ~phase_r;
  // Idle slots repeat the last word so no stale half is mixed in
  assign head     = fifo_valid ? fifo_data[`WORD_W-1:0] : word_r;

  always @*
  begin
    tgt_mode = `PWR_NORMAL;
    if (ser_ovr_r)
      tgt_mode = ser_mode_r;
    else if (tri_level_power_pin == `PIN_FLOAT)
      tgt_mode = `PWR_SLEEP;
    else if (tri_level_power_pin == `PIN_SUPPLY)
      tgt_mode = `PWR_NAP;
  end

  always @*
  begin
    clamped = sample_over ? {`WORD_W{1'b1}} : sample_data;
    case (fmt_sel)
      `FMT_TWOS_COMP: enc = {~clamped[`WORD_W-1], clamped[`WORD_W-2:0]};
      `FMT_GRAY:      enc = clamped ^ {1'b0, clamped[`WORD_W-1:1]};
      default:        enc = clamped;
    endcase
  end

  // Odd bits on low phase, even on high
  always @*
  begin
    half_bits = {`PAIR_N{1'b0}};
    for (i = 0; i < `PAIR_N; i = i + 1)
      half_bits[i] = phase_r ? word_r[2*i] : head[2*i+1];
  end

  // Power state sequencing
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r       <= ST_RUN;
      cnt_r      <= 20'h00000;
      ser_ovr_r  <= 1'b0;
      ser_mode_r <= `PWR_NORMAL;
      nap_stop_r <= 1'b0;
      power_mode <= `PWR_NORMAL;
      ready      <= 1'b1;
      locked     <= 1'b1;
    end
    else
    begin
      if (pwr_wr && pwr_wr_idx_ok)
      begin
        if (pwr_wr_data[3:1] == `WAKE_CODE)
        begin
          ser_ovr_r  <= 1'b1;
          ser_mode_r <= `PWR_NORMAL;
        end
        else if (pwr_wr_data[3:1] == 3'h2)
        begin
          ser_ovr_r  <= 1'b1;
          ser_mode_r <= `PWR_NAP;
        end
        else if (pwr_wr_data[3:1] == 3'h4)
        begin
          ser_ovr_r  <= 1'b1;
          ser_mode_r <= `PWR_SLEEP;
        end
      end
      case (st_r)
        ST_RUN:
        begin
          ready <= 1'b1;
          if (clock_freq_change)
          begin
            st_r   <= ST_LOCK;
            cnt_r  <= LOCK_CNT;
            ready  <= 1'b0;
            locked <= 1'b0;
          end
          else if (tgt_mode != `PWR_NORMAL)
          begin
            st_r       <= ST_LOW;
            power_mode <= tgt_mode;
            nap_stop_r <= 1'b0;
            ready      <= 1'b0;
          end
        end
        ST_LOW:
        begin
          if (clock_stopped)
            nap_stop_r <= 1'b1;
          if (tgt_mode != power_mode)
          begin
            if (tgt_mode == `PWR_NORMAL)
            begin
              st_r  <= ST_WAKE;
              // Wake times; 1ms from sleep, 1us from nap
              cnt_r <= (power_mode == `PWR_SLEEP) ? SLEEP_CNT : NAP_CNT;
            end
            power_mode <= tgt_mode;
          end
        end
        ST_WAKE:
        begin
          if (cnt_r > 20'h00001)
            cnt_r <= cnt_r - 20'h00001;
          else if (nap_stop_r)
          begin
            st_r       <= ST_LOCK;
            cnt_r      <= LOCK_CNT;
            nap_stop_r <= 1'b0;
            locked     <= 1'b0;
          end
          else
            st_r <= ST_RUN;
        end
        ST_LOCK:
        begin
          if (cnt_r > 20'h00001)
            cnt_r <= cnt_r - 20'h00001;
          else
          begin
            st_r   <= ST_RUN;
            locked <= 1'b1;
          end
        end
        default:
          st_r <= ST_RUN;
      endcase
    end
  end

  // Latency pipe of whole cycles; half cycle added by strobe phase
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lat_v_r  <= {`LAT_FULL{1'b0}};
      lat_o_r  <= {`LAT_FULL{1'b0}};
      div_ph_r <= 1'b0;
    end
    else
    begin
      div_ph_r <= ~div_ph_r;
      if (tick)
      begin
        lat_v_r <= {lat_v_r[`LAT_FULL-2:0], sample_valid};
        // Flag any sample clamped to full scale
        lat_o_r <= {lat_o_r[`LAT_FULL-2:0], &clamped};
      end
    end
  end

  always @(posedge clock)
  begin
    if (tick)
    begin
      lat_d_r[0] <= enc;
      for (j = 1; j < `LAT_FULL; j = j + 1)
        lat_d_r[j] <= lat_d_r[j-1];
    end
  end

  word_fifo #(
    .WIDTH (`WORD_W + 1),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .flush     (~calibration_reset_n),
    .in_data   ({lat_o_r[`LAT_FULL-1], lat_d_r[`LAT_FULL-1]}),
    .in_valid  (tick & lat_v_r[`LAT_FULL-1]),
    .in_ready  (),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Output stage: strobe, data, over-range, enables
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_r                 <= 1'b0;
      forwarded_output_strobe <= 1'b0;
      strobe_oe               <= 1'b1;
      data_pair_o             <= {`PAIR_N{1'b0}};
      data_pair_oe            <= {`PAIR_N{1'b1}};
      over_range_o            <= 1'b1;
      over_range_oe           <= 1'b1;
      drive_2ma               <= `DRIVE_3MA;
      word_r                  <= {`WORD_W{1'b0}};
      or_r                    <= 1'b0;
    end
    else
    begin
      drive_2ma <= drive_low_sel;
      // Outputs released while napping or asleep
      strobe_oe     <= (power_mode == `PWR_NORMAL);
      data_pair_oe  <= {`PAIR_N{power_mode == `PWR_NORMAL}};
      over_range_oe <= (power_mode == `PWR_NORMAL);
      if (!calibration_reset_n)
      begin
        // Strobe low, flag high in reset
        phase_r                 <= 1'b0;
        forwarded_output_strobe <= 1'b0;
        over_range_o            <= 1'b1;
      end
      else if (out_en && tick)
      begin
        // Two half words per strobe period
        phase_r                 <= ~phase_r;
        forwarded_output_strobe <= phase_r;
        data_pair_o             <= half_bits;
        // Flag per sample, held until calibration done
        if (!phase_r)
        begin
          word_r <= head;
          if (fifo_valid)
            or_r <= fifo_data[`WORD_W];
        end
        over_range_o <= cal_done ? or_r : 1'b1;
      end
    end
  end
endmodule

/* File: verification/adc_fmt_power_asserts.sv */
// Port checker for the output formatting and power control block
`timescale 1ns/1ps
module adc_fmt_power_asserts #(
  parameter SLEEP_WAKE = 50,
  parameter RELOCK     = 20
) (
  input logic       clock,
  input logic       arst_n,
  input logic       calibration_reset_n,
  input logic       cal_done,
  input logic       sample_valid,
  input logic       sample_over,
  input logic       div2_sel,
  input logic       drive_low_sel,
  input logic       clock_freq_change,
  input logic       pwr_wr,
  input logic [3:0] pwr_wr_data,
  input logic       pwr_wr_idx_ok,
  input logic [4:0] data_pair_oe,
  input logic       strobe_oe,
  input logic       over_range_oe,
  input logic       forwarded_output_strobe,
  input logic       over_range_o,
  input logic       drive_2ma,
  input logic [1:0] power_mode,
  input logic       ready,
  input logic       locked
);
  localparam int SLW_LO = SLEEP_WAKE / 2;
  localparam int SLW_HI = SLEEP_WAKE / 2 + RELOCK + 8;
  localparam int NAP_HI = 28 + RELOCK;
  localparam int RL_HI  = RELOCK + 8;
  wire [2:0] code = pwr_wr_data[3:1];
  wire       known = (code == 3'h1) || (code == 3'h2) || (code == 3'h4);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_slept;
    power_mode == 2'h0 && $past(power_mode) == 2'h2;
  endsequence
  sequence s_waking;
    ##SLW_LO !ready ##[1:SLW_HI] ready;
  endsequence
  property p_oe_off;
    (power_mode != 2'h0)[*2] |-> data_pair_oe == 5'h0 && !strobe_oe && !over_range_oe;
  endproperty
  property p_drive;
    $stable(drive_low_sel)[*2] |-> drive_2ma == drive_low_sel;
  endproperty
  property p_cal_flag;
    (!calibration_reset_n || !cal_done) |=> over_range_o;
  endproperty
  property p_cal_strobe;
    !calibration_reset_n |=> !forwarded_output_strobe;
  endproperty
  property p_ddr_toggle;
    (power_mode == 2'h0 && ready && calibration_reset_n && !div2_sel)[*3]
      |-> forwarded_output_strobe != $past(forwarded_output_strobe);
  endproperty
  property p_ovr;
    sample_valid && sample_over && cal_done && ready && power_mode == 2'h0 |-> ##[1:60] over_range_o;
  endproperty
  property p_pwr_cmd;
    pwr_wr && pwr_wr_idx_ok && known
      |-> ##[1:2] power_mode == (code == 3'h1 ? 2'h0 : code == 3'h2 ? 2'h1 : 2'h2);
  endproperty
  property p_pwr_ign;
    pwr_wr && (!pwr_wr_idx_ok || !known) |=> $stable(power_mode)[*2];
  endproperty
  property p_sleep_wake;
    s_slept |-> s_waking;
  endproperty
  property p_nap_wake;
    power_mode == 2'h0 && $past(power_mode) == 2'h1 |-> ##[1:NAP_HI] ready;
  endproperty
  property p_relock;
    clock_freq_change |-> ##[1:2] !locked ##[1:RL_HI] locked;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while powered down");
  a_drive: assert property (p_drive) else $error("drive level not following select");
  a_cal_flag: assert property (p_cal_flag) else $error("flag low during calibration");
  a_cal_strobe: assert property (p_cal_strobe) else $error("strobe high in calibration reset");
  a_ddr_toggle: assert property (p_ddr_toggle) else $error("strobe not toggling");
  a_ovr: assert property (p_ovr) else $error("over range flag missing");
  a_pwr_cmd: assert property (p_pwr_cmd) else $error("power command not applied");
  a_pwr_ign: assert property (p_pwr_ign) else $error("ignored power write changed mode");
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake timing wrong");
  a_nap_wake: assert property (p_nap_wake) else $error("nap wake too slow");
  a_relock: assert property (p_relock) else $error("relock timing wrong");
endmodule

bind adc_output_format_power_ctrl adc_fmt_power_asserts #(.SLEEP_WAKE(SLEEP_WAKE), .RELOCK(RELOCK)) u_chk (.*);

/* File: verification/ddr_word_capture.sv */
// Receiver model assembling DDR words with the forwarded strobe
`timescale 1ns/1ps
module ddr_word_capture (
  input  wire       clock,
  input  wire [4:0] data_pair_o,
  input  wire       forwarded_output_strobe,
  input  wire       strobe_oe,
  output reg  [9:0] rx_word,
  output reg        rx_stb
);
  reg     [4:0] odd_r;
  integer       i;
  initial rx_stb = 1'b0;
  always @(posedge clock)
  begin
    rx_stb <= 1'b0;
    if (strobe_oe && !forwarded_output_strobe)
      odd_r <= data_pair_o;
    else if (strobe_oe)
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        rx_word[2*i+1] <= odd_r[i];
        rx_word[2*i]   <= data_pair_o[i];
      end
      rx_stb <= 1'b1;
    end
  end
endmodule

/* File: verification/adc_output_format_power_ctrl_tb_top.sv */
// Testbench for the output formatting and power control block
`timescale 1ns/1ps
module adc_output_format_power_ctrl_tb_top;
  localparam SW = 50;
  localparam RL = 20;
  reg        clock, arst_n, calibration_reset_n, cal_done, sample_valid, sample_over, serial_select_n;
  reg        clock_freq_change, drive_low_sel, div2_sel, pwr_wr, pwr_wr_idx_ok, or_seen, clock_stopped;
  reg  [9:0] sample_data;
  reg  [1:0] tri_level_power_pin, fmt_sel;
  reg  [3:0] pwr_wr_data;
  wire [4:0] data_pair_o, data_pair_oe;
  wire [1:0] power_mode;
  wire [9:0] rx_word;
  wire       forwarded_output_strobe, strobe_oe, over_range_o, over_range_oe, drive_2ma, ready, locked, rx_stb;
  integer    n_errors, compares, k, f, v;
  reg  [9:0] vals [0:4] = '{10'h000, 10'h001, 10'h200, 10'h3fe, 10'h3ff};
  reg  [9:0] ob;

  adc_output_format_power_ctrl #(.SLEEP_WAKE(SW), .RELOCK(RL)) DUT (
    .clock(clock), .arst_n(arst_n), .calibration_reset_n(calibration_reset_n), .cal_done(cal_done),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_over(sample_over),
    .tri_level_power_pin(tri_level_power_pin), .serial_select_n(serial_select_n), .clock_stopped(clock_stopped),
    .clock_freq_change(clock_freq_change), .fmt_sel(fmt_sel), .drive_low_sel(drive_low_sel),
    .div2_sel(div2_sel), .pwr_wr(pwr_wr), .pwr_wr_data(pwr_wr_data), .pwr_wr_idx_ok(pwr_wr_idx_ok),
    .data_pair_o(data_pair_o), .data_pair_oe(data_pair_oe), .forwarded_output_strobe(forwarded_output_strobe),
    .strobe_oe(strobe_oe), .over_range_o(over_range_o), .over_range_oe(over_range_oe),
    .drive_2ma(drive_2ma), .power_mode(power_mode), .ready(ready), .locked(locked));

  ddr_word_capture u_rx (.clock(clock), .data_pair_o(data_pair_o), .forwarded_output_strobe(forwarded_output_strobe),
    .strobe_oe(strobe_oe), .rx_word(rx_word), .rx_stb(rx_stb));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task chk(input [9:0] seen, input [9:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask

  // Valid held two cycles so one tick takes it with the halved rate too
  task xfer(input [9:0] d, input o, input [9:0] e);
  begin
    sample_data = d;
    sample_over = o;
    sample_valid = 1'b1;
    or_seen = 1'b0;
    cyc(2);
    sample_valid = 1'b0;
    for (k = 0; k < 90 && !(rx_stb === 1'b1 && rx_word === e); k = k + 1)
    begin
      or_seen = or_seen | (over_range_o === 1'b1);
      cyc(1);
    end
    chk(rx_word, e);
    cyc(4);
    or_seen = or_seen | (over_range_o === 1'b1);
  end
  endtask

  task pwr(input [3:0] c, input i);
  begin
    pwr_wr_data = c;
    pwr_wr_idx_ok = i;
    pwr_wr = 1'b1;
    cyc(1);
    pwr_wr = 1'b0;
    cyc(4);
  end
  endtask

  // Bounded wait on ready (sel 0) or locked (sel 1)
  task wait_for(input sel);
    for (k = 0; k < 300 && ((sel ? locked : ready) !== 1'b1); k = k + 1)
      cyc(1);
  endtask

  task print_verdict;
  begin
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  initial
  begin
    cyc(20000);
    n_errors = n_errors + 1;
    print_verdict;
  end

  initial
  begin
    n_errors = 0;
    compares = 0;
    {arst_n, sample_valid, sample_over, clock_freq_change, drive_low_sel, div2_sel, pwr_wr, pwr_wr_idx_ok} = 8'h0;
    {calibration_reset_n, cal_done, serial_select_n} = 3'h7;
    sample_data = 10'h0;
    tri_level_power_pin = 2'h0;
    fmt_sel = 2'h0;
    pwr_wr_data = 4'h0;
    clock_stopped = 1'b0;
    cyc(8);
    arst_n = 1'b1;
    cyc(4);
    for (f = 0; f < 3; f = f + 1)
      for (v = 0; v < 5; v = v + 1)
      begin
        fmt_sel = f[1:0];
        ob = vals[v];
        xfer(ob, 1'b0, f == 0 ? ob : f == 1 ? ob ^ 10'h200 : ob ^ (ob >> 1));
      end
    fmt_sel = 2'h0;
    xfer(10'h155, 1'b1, 10'h3ff);
    chk(or_seen, 1'b1);
    xfer(10'h0aa, 1'b0, 10'h0aa);
    chk(over_range_o, 1'b0);
    div2_sel = 1'b1;
    xfer(10'h2a5, 1'b0, 10'h2a5);
    div2_sel = 1'b0;
    drive_low_sel = 1'b1;
    cyc(3);
    chk(drive_2ma, 1'b1);
    drive_low_sel = 1'b0;
    cyc(3);
    chk(drive_2ma, 1'b0);
    calibration_reset_n = 1'b0;
    cyc(3);
    chk({forwarded_output_strobe, over_range_o}, 2'h1);
    calibration_reset_n = 1'b1;
    cal_done = 1'b0;
    cyc(3);
    chk(over_range_o, 1'b1);
    cal_done = 1'b1;
    for (v = 2; v > 0; v = v - 1)
    begin
      tri_level_power_pin = v[1:0];
      cyc(4);
      chk(power_mode, v == 2 ? 2'h1 : 2'h2);
      chk({data_pair_oe, strobe_oe, over_range_oe}, 7'h0);
    end
    tri_level_power_pin = 2'h0;
    wait_for(1'b0);
    chk({power_mode, ready}, 3'h1);
    pwr(4'h8, 1'b1);
    chk(power_mode, 2'h2);
    pwr(4'h0, 1'b1);
    pwr(4'he, 1'b1);
    chk(power_mode, 2'h2);
    pwr(4'h2, 1'b0);
    chk(power_mode, 2'h2);
    serial_select_n = 1'b0;
    cyc(3000);
    pwr(4'h3, 1'b1);
    chk({power_mode, ready}, 3'h0);
    wait_for(1'b0);
    chk(k >= SW - 10 && ready === 1'b1, 1'b1);
    serial_select_n = 1'b1;
    pwr(4'h4, 1'b1);
    chk(power_mode, 2'h1);
    pwr(4'h2, 1'b1);
    wait_for(1'b0);
    chk(k <= 30 && ready === 1'b1, 1'b1);
    xfer(10'h1c3, 1'b0, 10'h1c3);
    pwr(4'h4, 1'b1);
    clock_stopped = 1'b1;
    cyc(2);
    clock_stopped = 1'b0;
    pwr(4'h2, 1'b1);
    cyc(20);
    chk(locked, 1'b0);
    wait_for(1'b0);
    chk(k >= RL - 10 && k <= RL + 10 && ready === 1'b1, 1'b1);
    clock_freq_change = 1'b1;
    cyc(1);
    clock_freq_change = 1'b0;
    cyc(1);
    chk(locked, 1'b0);
    wait_for(1'b1);
    chk(k <= RL + 10 && locked === 1'b1, 1'b1);
    print_verdict;
  end
endmodule
